// ---- lsis_status.sv ----
`timescale 1ns/10ps
`include "lsis_params.svh"
// What this block does
// - report fault kind code, read-only, no interrupt
// - transmit state code read-only, no interrupt
// - receive state code read-only, no interrupt
// - normal summary ORs unmasked 0,2,6,11,14
// - abnormal summary ORs unmasked abnormal bits
// - set early receive after first buffer
// - frame received clears early receive flag
// - system fault halts DMA until cleared
// - link loss sets on link fail entry
// - force control bit also sets link flag
// - write one clears, zero leaves bit
// - reads never clear status bits
// - per-bit mask gates summaries and interrupt
module lsis_status
  import lsis_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [14:0] evt_set,
  input wire logic first_buffer_done,
  input wire logic link_fail_entry,
  input wire logic [2:0] fault_kind_code,
  input wire logic [2:0] tx_process_state,
  input wire logic [2:0] rx_process_state,
  output logic dma_halt,
  output logic irq,
  output logic soft_reset
);

  lsis_state_s s_q; // all registered state
  lsis_state_s s_d; // next state
  logic setup; // apb setup phase
  logic wr_acc; // write taken this edge
  logic [14:0] hw_set; // hardware set requests per event bit
  logic [14:0] w1c; // software clear requests per event bit
  logic normal_summary; // masked normal or
  logic abnormal_summary; // masked abnormal or
  logic sw_rst; // software reset pulse
  logic [14:0] evt_upd; // event bits after set and clear, before the interlock

  // address decode, used for read mux and write strobes
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    unique case (a)
      `LSIS_OFF_STATUS: reg_sel = 2'h1;
      `LSIS_OFF_MASK: reg_sel = 2'h2;
      `LSIS_OFF_CTRL: reg_sel = 2'h3;
      default: reg_sel = 2'h0;
    endcase
  endfunction

  // summaries only see unmasked bits
  assign normal_summary = |(s_q.evt & s_q.mask & `LSIS_NORMAL_SET);
  assign abnormal_summary = |(s_q.evt & s_q.mask & `LSIS_ABNORMAL_SET);

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign sw_rst = wr_acc && reg_sel(paddr) == 2'h3 && pwdata[`LSIS_CTL_SRST];

  // every event bit is the same sticky flop; a set request beats a clear in the
  // same cycle so an event arriving during the service write is never lost
  for (genvar gi = 0; gi < `LSIS_EVT_W; gi++) begin : g_evt
    assign evt_upd[gi] = (s_q.evt[gi] && !w1c[gi]) || hw_set[gi];
  end

  // merge event sources; early receive and link flag have own inputs
  always_comb begin
    hw_set = evt_set;
    hw_set[`LSIS_BIT_ER] = first_buffer_done;
    hw_set[`LSIS_BIT_LF] = link_fail_entry || s_q.force_lf;
    w1c = (wr_acc && reg_sel(paddr) == 2'h1) ? pwdata[14:0] : 15'h0000;
  end

  // next-state logic; reads have no side effect
  always_comb begin
    s_d = s_q;
    // set wins over a clear in the same cycle
    s_d.evt = evt_upd;
    // frame received clears early receive; if both arrive at once, ri wins
    if (s_d.evt[`LSIS_BIT_RI]) begin
      s_d.evt[`LSIS_BIT_ER] = 1'b0;
    end
    unique case (s_q.bus)
      LSIS_IDLE: begin
        if (setup) begin
          s_d.bus = LSIS_ACC;
        end
      end
      LSIS_ACC: begin
        s_d.bus = LSIS_IDLE;
      end
      default: s_d.bus = LSIS_IDLE;
    endcase
    // capture read data in setup so it is a flop in access
    if (setup && !pwrite) begin
      unique case (reg_sel(paddr))
        2'h1: s_d.rdata = {6'h00, fault_kind_code, tx_process_state, rx_process_state,
                           normal_summary, abnormal_summary, s_q.evt};
        2'h2: s_d.rdata = {17'h00000, s_q.mask};
        2'h3: s_d.rdata = {21'h000000, s_q.force_lf, 10'h000};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    if (wr_acc && reg_sel(paddr) == 2'h2) begin
      s_d.mask = pwdata[14:0];
    end
    if (wr_acc && reg_sel(paddr) == 2'h3) begin
      s_d.force_lf = pwdata[`LSIS_CTL_FORCE_LF];
    end
    // software reset returns status and masks to reset values
    if (sw_rst) begin
      s_d.evt = `LSIS_EVT_RST;
      s_d.mask = `LSIS_MASK_RST;
      s_d.force_lf = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q.evt <= `LSIS_EVT_RST;
      s_q.mask <= `LSIS_MASK_RST;
      s_q.force_lf <= 1'b0;
      s_q.bus <= LSIS_IDLE;
      s_q.rdata <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  // zero-wait slave, unmapped reads zero with error
  assign pready = 1'b1;
  assign pslverr = psel && penable && reg_sel(paddr) == 2'h0;
  assign prdata = s_q.rdata;
  assign dma_halt = s_q.evt[`LSIS_BIT_SE];
  assign irq = normal_summary || abnormal_summary;
  assign soft_reset = sw_rst;

  // a fault flag that nobody clears keeps dma stopped
  a_sefault_halt: assert property (@(posedge mclk) disable iff (!resetn)
    s_q.evt[`LSIS_BIT_SE] && !w1c[`LSIS_BIT_SE] && !sw_rst |=> dma_halt)
    else $error("dma halt dropped while fault set");
  a_er_ri_excl: assert property (@(posedge mclk) disable iff (!resetn)
    !(s_q.evt[`LSIS_BIT_ER] && s_q.evt[`LSIS_BIT_RI]))
    else $error("early and frame received both set");
  a_er_set: assert property (@(posedge mclk) disable iff (!resetn)
    first_buffer_done && !s_d.evt[`LSIS_BIT_RI] && !sw_rst |=> s_q.evt[`LSIS_BIT_ER])
    else $error("early receive not set");
  a_lf_force: assert property (@(posedge mclk) disable iff (!resetn)
    (link_fail_entry || s_q.force_lf) && !sw_rst |=> s_q.evt[`LSIS_BIT_LF])
    else $error("link loss flag not set");
  a_w1c_clear: assert property (@(posedge mclk) disable iff (!resetn)
    wr_acc && paddr == `LSIS_OFF_STATUS && pwdata[0] && !evt_set[0] |=> !s_q.evt[0])
    else $error("write one did not clear");
  a_read_keep: assert property (@(posedge mclk) disable iff (!resetn)
    psel && !pwrite && s_q.evt[3] && !sw_rst |=> s_q.evt[3])
    else $error("read cleared a bit");
  a_normal_sum: assert property (@(posedge mclk) disable iff (!resetn)
    s_q.evt[6] && s_q.mask[6] |-> s_q.rdata[`LSIS_BIT_NS] || !$past(setup) || $past(paddr) != `LSIS_OFF_STATUS
      || $past(pwrite) || !$past(s_q.evt[6] && s_q.mask[6]))
    else $error("normal summary missing");
  a_masked_out: assert property (@(posedge mclk) disable iff (!resetn)
    s_q.mask == 15'h0000 |-> !irq)
    else $error("masked event raised request");
  a_irq_follow: assert property (@(posedge mclk) disable iff (!resetn)
    irq == (|(s_q.evt & s_q.mask & 15'h7BFF)))
    else $error("request not tied to summaries");

  // checks below pin the status word to its rules;
  // each one watches state, inputs or outputs of this block only

  // writing one to the fault flag or a software reset lets dma run again;
  // a fresh fault in the same cycle as the clear keeps it stopped
  a_halt_release: assert property (@(posedge mclk) disable iff (!resetn)
    dma_halt && (sw_rst || (w1c[`LSIS_BIT_SE] && !hw_set[`LSIS_BIT_SE])) |=> !dma_halt)
    else $error("dma halt not released");

  // a new fault stops dma from the next cycle on
  a_halt_on_set: assert property (@(posedge mclk) disable iff (!resetn)
    hw_set[`LSIS_BIT_SE] && !sw_rst |=> dma_halt)
    else $error("fault did not halt dma");

  // the fault kind code is display only;
  // a change of it with steady events must not move the request
  a_fault_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    $changed(fault_kind_code) && $stable(s_q.evt) && $stable(s_q.mask) |-> $stable(irq))
    else $error("fault code moved the request");

  // transmit state changes never raise a request by themselves
  a_txs_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    $changed(tx_process_state) && $stable(s_q.evt) && $stable(s_q.mask) |-> $stable(irq))
    else $error("transmit state moved the request");

  // receive state changes never raise a request by themselves
  a_rxs_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    $changed(rx_process_state) && $stable(s_q.evt) && $stable(s_q.mask) |-> $stable(irq))
    else $error("receive state moved the request");

  // a status read shows the fault code seen at its setup edge;
  // the code is live, so software must qualify it with the fault flag
  a_fkc_read: assert property (@(posedge mclk) disable iff (!resetn)
    setup && !pwrite && paddr == `LSIS_OFF_STATUS |=> s_q.rdata[`LSIS_FKC_HI:`LSIS_FKC_LO] == $past(fault_kind_code))
    else $error("fault code not in status word");

  // transmit state lands in its own field
  a_txs_read: assert property (@(posedge mclk) disable iff (!resetn)
    setup && !pwrite && paddr == `LSIS_OFF_STATUS |=> s_q.rdata[`LSIS_TXS_HI:`LSIS_TXS_LO] == $past(tx_process_state))
    else $error("transmit state not in status word");

  // receive state lands in its own field
  a_rxs_read: assert property (@(posedge mclk) disable iff (!resetn)
    setup && !pwrite && paddr == `LSIS_OFF_STATUS |=> s_q.rdata[`LSIS_RXS_HI:`LSIS_RXS_LO] == $past(rx_process_state))
    else $error("receive state not in status word");

  // any unmasked abnormal event shows in the abnormal summary
  a_abn_sum: assert property (@(posedge mclk) disable iff (!resetn)
    setup && !pwrite && paddr == `LSIS_OFF_STATUS && abnormal_summary |=> s_q.rdata[`LSIS_BIT_AS])
    else $error("abnormal summary missing");

  // masked or absent normal events leave the normal summary clear;
  // this is what lets software poll without taking stale requests
  a_norm_clear: assert property (@(posedge mclk) disable iff (!resetn)
    setup && !pwrite && paddr == `LSIS_OFF_STATUS && !normal_summary |=> !s_q.rdata[`LSIS_BIT_NS])
    else $error("normal summary set without cause");

  // request drops once both summaries are clear
  a_irq_drop: assert property (@(posedge mclk) disable iff (!resetn)
    !normal_summary && !abnormal_summary |-> !irq)
    else $error("request held without summary");

  // a received frame leaves the early flag clear on the next cycle
  a_ri_clears_er: assert property (@(posedge mclk) disable iff (!resetn)
    hw_set[`LSIS_BIT_RI] && !sw_rst |=> !s_q.evt[`LSIS_BIT_ER])
    else $error("early flag kept beside frame flag");

  // writing zero to a pending bit leaves it pending
  a_zero_keep: assert property (@(posedge mclk) disable iff (!resetn)
    wr_acc && paddr == `LSIS_OFF_STATUS && !pwdata[5] && s_q.evt[5] |=> s_q.evt[5])
    else $error("zero write cleared a bit");

  // the check expects each access phase to follow a setup;
  // the write decode ignores the bus tracker, so a stray enable would write
  a_bus_phase: assert property (@(posedge mclk) disable iff (!resetn)
    psel && penable |-> s_q.bus == LSIS_ACC)
    else $error("access phase without setup");

  // force bit is a plain control flop
  a_force_reg: assert property (@(posedge mclk) disable iff (!resetn)
    wr_acc && paddr == `LSIS_OFF_CTRL && pwdata[`LSIS_CTL_FORCE_LF] && !pwdata[`LSIS_CTL_SRST] |=> s_q.force_lf)
    else $error("force bit not stored");

  // every event has its own enable, written as one word
  a_mask_write: assert property (@(posedge mclk) disable iff (!resetn)
    wr_acc && paddr == `LSIS_OFF_MASK |=> s_q.mask == $past(pwdata[14:0]))
    else $error("mask write lost");

  // software reset empties status, masks and force bit;
  // any event in the same cycle is dropped with it
  a_srst_clear: assert property (@(posedge mclk) disable iff (!resetn)
    soft_reset |=> s_q.evt == `LSIS_EVT_RST && s_q.mask == `LSIS_MASK_RST && !s_q.force_lf)
    else $error("software reset left state");

  // the status word is mapped, so its access never errors
  a_pslverr_map: assert property (@(posedge mclk) disable iff (!resetn)
    psel && penable && paddr == `LSIS_OFF_STATUS |-> !pslverr)
    else $error("status access flagged error");

  // control reads return the force bit in place
  a_ctrl_read: assert property (@(posedge mclk) disable iff (!resetn)
    setup && !pwrite && paddr == `LSIS_OFF_CTRL |=> s_q.rdata[`LSIS_CTL_FORCE_LF] == $past(s_q.force_lf))
    else $error("force bit not readable");

  // a pending event stays until cleared or reset
  a_evt_hold: assert property (@(posedge mclk) disable iff (!resetn)
    s_q.evt[9] && !w1c[9] && !sw_rst |=> s_q.evt[9])
    else $error("event bit lost");

  // read data only moves at a setup edge;
  // a slow master sees the same word for the whole access
  a_rdata_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !setup |=> $stable(s_q.rdata))
    else $error("read data moved outside setup");

  // no pending event, no request
  a_idle_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    s_q.evt == `LSIS_EVT_RST |-> !irq)
    else $error("request with empty status");
endmodule

// ---- lsis_params.svh ----
`ifndef LSIS_PARAMS_SVH
`define LSIS_PARAMS_SVH
// register byte offsets
`define LSIS_OFF_STATUS 12'h000
`define LSIS_OFF_MASK 12'h004
`define LSIS_OFF_CTRL 12'h008
// status field positions
`define LSIS_FKC_HI 25
`define LSIS_FKC_LO 23
`define LSIS_TXS_HI 22
`define LSIS_TXS_LO 20
`define LSIS_RXS_HI 19
`define LSIS_RXS_LO 17
`define LSIS_BIT_NS 16
`define LSIS_BIT_AS 15
`define LSIS_BIT_ER 14
`define LSIS_BIT_SE 13
`define LSIS_BIT_LF 12
`define LSIS_BIT_RI 6
// event bits feeding each summary
`define LSIS_NORMAL_SET 15'h4845
`define LSIS_ABNORMAL_SET 15'h33BA
`define LSIS_EVT_W 15
// control register fields
`define LSIS_CTL_FORCE_LF 10
`define LSIS_CTL_SRST 0
// reset values
`define LSIS_EVT_RST 15'h0000
`define LSIS_MASK_RST 15'h0000
`endif

// ---- lsis_pkg.sv ----
package lsis_pkg;
  typedef logic [14:0] lsis_evt_t;
  typedef enum logic [1:0] {
    LSIS_IDLE = 2'b01,
    LSIS_ACC = 2'b10
  } lsis_bus_e;
  typedef struct packed {
    lsis_evt_t evt;
    lsis_evt_t mask;
    logic force_lf;
    lsis_bus_e bus;
    logic [31:0] rdata;
  } lsis_state_s;
endpackage

// ---- testbench.sv ----
`timescale 1ns/10ps
`include "lsis_params.svh"
// reads are noted in a queue; a monitor judges them in their access phase
module testbench
  import lsis_pkg::*;
;
  logic mclk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic first_buffer_done = 1'h0, link_fail_entry = 1'h0; // event pulses
  logic pready, pslverr, dma_halt, irq, soft_reset;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h6E0D, r;
  logic [14:0] evt_set = 15'h0, ev = 15'h0, msk = 15'h0; // bench copy of events and masks
  logic [2:0] fault_kind_code = 3'h0, tx_process_state = 3'h0, rx_process_state = 3'h0;
  logic [32:0] e;
  logic [32:0] expq[$]; // notes of {pslverr, prdata}
  int num_errors = 0, total_checks = 0;
  always #20 mclk = ~mclk;
  lsis_status u_dut(.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .evt_set, .first_buffer_done, .link_fail_entry, .fault_kind_code, .tx_process_state, .rx_process_state,
    .dma_halt, .irq, .soft_reset);
  // shift register step for random stimulus
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // expected status word, built from the bench copy
  function automatic logic [32:0] st();
    return {7'h00, fault_kind_code, tx_process_state, rx_process_state,
      |(ev & msk & `LSIS_NORMAL_SET), |(ev & msk & `LSIS_ABNORMAL_SET), ev};
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin num_errors++; close_out(); end
    psel <= 1'h0; penable <= 1'h0;
    @(posedge mclk); // idle cycle so the next call never re-drives psel in this step
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    expq.push_back(x);
    apb(1'h0, a, 32'h0);
  endtask
  // one-cycle event pulse, mirrored in the bench copy
  task automatic evt(input logic [14:0] s, input logic fb, input logic lf);
    evt_set <= s; first_buffer_done <= fb; link_fail_entry <= lf;
    @(posedge mclk);
    evt_set <= 15'h0; first_buffer_done <= 1'h0; link_fail_entry <= 1'h0;
    @(posedge mclk);
    ev = ev | s | {fb, 1'h0, lf, 12'h000};
    if (ev[6]) ev[14] = 1'h0; // a pending received frame keeps the early flag clear
  endtask
  // irq and halt levels, sampled away from the edge so they have settled
  task automatic lvl();
    @(negedge mclk);
    e = st();
    chk({31'h0, dma_halt, irq}, {31'h0, ev[13], e[16] | e[15]});
    @(posedge mclk);
  endtask
  // monitor: oldest note against each completed read
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'h1 && !pwrite && expq.size() > 0) chk({pslverr, prdata}, expq.pop_front());
    if (psel && penable && pwrite)
      chk({32'h0, soft_reset}, {32'h0, paddr == `LSIS_OFF_CTRL && pwdata[`LSIS_CTL_SRST]});
  end
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'h1;
    r = rnd();
    fault_kind_code <= r[2:0];
    tx_process_state <= r[5:3];
    rx_process_state <= r[8:6];
    @(posedge mclk);
    evt(15'h0, 1'h0, 1'h0);
    rd(`LSIS_OFF_STATUS, st());
    rd(12'h00C, {1'h1, 32'h0});
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      apb(1'h1, `LSIS_OFF_MASK, r);
      msk = r[14:0];
      r = rnd();
      evt(r[14:0] & 15'h2FFF, r[20], r[21]);
      rd(`LSIS_OFF_STATUS, st());
      rd(`LSIS_OFF_STATUS, st());
      lvl();
      r = rnd();
      apb(1'h1, `LSIS_OFF_STATUS, r);
      ev = ev & ~r[14:0];
      rd(`LSIS_OFF_STATUS, st());
    end
    apb(1'h1, `LSIS_OFF_MASK, 32'h7FFF);
    msk = 15'h7FFF;
    rd(`LSIS_OFF_MASK, 33'h000007FFF);
    evt(15'h0, 1'h1, 1'h0);
    rd(`LSIS_OFF_STATUS, st());
    evt(15'h0040, 1'h1, 1'h1);
    rd(`LSIS_OFF_STATUS, st());
    apb(1'h1, `LSIS_OFF_CTRL, 32'h400);
    rd(`LSIS_OFF_CTRL, 33'h000000400);
    apb(1'h1, `LSIS_OFF_STATUS, 32'h7FFF);
    ev = 15'h1000;
    rd(`LSIS_OFF_STATUS, st());
    apb(1'h1, `LSIS_OFF_CTRL, 32'h0);
    apb(1'h1, `LSIS_OFF_STATUS, 32'h1000);
    ev = 15'h0;
    rd(`LSIS_OFF_STATUS, st());
    evt(15'h2000, 1'h0, 1'h0);
    lvl();
    rd(`LSIS_OFF_STATUS, st());
    apb(1'h1, `LSIS_OFF_CTRL, 32'h1);
    ev = 15'h0;
    msk = 15'h0;
    rd(`LSIS_OFF_STATUS, st());
    lvl();
    if (expq.size() != 0) num_errors++;
    close_out();
  end
endmodule
